//--- verilog/pmwc_pkg.sv
// constants shared by both ends of the power mode and wake-up control link
package pmwc_pkg;
	localparam int          CLK_PERIOD_NS  = 40;
	localparam int          POR_TIME_NS    = 2_500_000;
	localparam int          POR_CYCLES     = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          FAST_WAKE_HOLD = 10;
	localparam logic [7:0]  OP_NOP         = 8'hff;
	localparam logic [7:0]  OP_STOP        = 8'h6f;
	localparam logic [7:0]  OP_HALT        = 8'h7f;
	localparam logic [15:0] RESTART_ADDR   = 16'h000c;
	// device register indices
	localparam logic [7:0]  REG_SUPPLY     = 8'h0c;
	localparam logic [7:0]  REG_STOPCFG    = 8'h0b;
	localparam logic [7:0]  REG_IRQ        = 8'h0a;
	localparam logic [7:0]  REG_MASK       = 8'h09;
	// field positions and reset values
	localparam int          SUP_EN         = 0;
	localparam int          SUP_LOW        = 1;
	localparam int          SUP_HIGH       = 2;
	localparam int          CFG_SRC_LO     = 2;
	localparam int          CFG_DLY        = 5;
	localparam int          CFG_POL        = 6;
	localparam int          CFG_WARM       = 7;
	localparam int          IRQ_FIVE       = 5;
	localparam logic        RST_DLY        = 1'b1;
	localparam logic        RST_POL        = 1'b0;
	// core side apb offsets and bit positions
	localparam logic [7:0]  APB_CMD        = 8'h00;
	localparam logic [7:0]  APB_DEVREG     = 8'h04;
	localparam logic [7:0]  APB_PINS       = 8'h08;
	localparam logic [7:0]  APB_CORE_IRQ   = 8'h0c;
	localparam logic [7:0]  APB_STATUS     = 8'h10;
	localparam int          DEV_WR_BIT     = 16;
	localparam int          STAT_SEEN      = 3;
endpackage

//--- verilog/pmwc_if.sv
// link between the power controller and the processor core side
`timescale 1ns/1ps
interface pmwc_if;
	logic       instr_stb;
	logic [7:0] instr_op;
	logic       reg_stb;
	logic       reg_wr;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_ack;
	logic [7:0] reg_rdata;
	logic       core_irq_pend;
	logic       interrupt_request_five_req;
	logic       exec_en;
	logic       cpu_clk_en;
	logic       restart;
	logic [7:0] port2_level;
	logic [7:0] port2_is_out;
	logic [3:0] wake_pins;

	modport dev (
		input  instr_stb, instr_op, reg_stb, reg_wr, reg_addr, reg_wdata,
		input  core_irq_pend, port2_level, port2_is_out, wake_pins,
		output reg_ack, reg_rdata, interrupt_request_five_req, exec_en, cpu_clk_en, restart
	);
	modport host (
		output instr_stb, instr_op, reg_stb, reg_wr, reg_addr, reg_wdata,
		output core_irq_pend, port2_level, port2_is_out, wake_pins,
		input  reg_ack, reg_rdata, interrupt_request_five_req, exec_en, cpu_clk_en, restart
	);
endinterface

//--- verilog/pmwc_device.sv
// power mode, reset delay, stop recovery and supply monitor controller
// Overview of operation
// [R1] delay one-shot starts on supply, watchdog, wake
// [R2] delay lasts at least its minimum time
// [R3] delay-select low skips delay; resets to one
// [R4] wake source held ten processor clocks; not checked here, wake_hit acts at once
// [R5] software keeps delay-select set with crystals
// [R6] halt stops cpu clock, keeps oscillator running
// [R7] halt exits on enabled interrupt only
// [R8] stop turns off clock and oscillator
// [R9] stop exits only by reset, restart fixed
// [R10] nop precedes every stop or halt
// [R11] three-bit field selects the wake source
// [R12] port two outputs drop out of nor
// [R13] polarity bit picks wake level, resets low
// [R14] warm bit reads one after stop wake
// [R15] monitor enable bit starts supply watching
// [R16] high and low flags follow thresholds
// [R17] low flag latches interrupt request five
// [R18] request five serviced only when unmasked
// [R19] software enables interrupts before monitoring
// [R20] execution held while delay runs
`timescale 1ns/1ps
module pmwc_device #(
	parameter int POR_CYCLES = pmwc_pkg::POR_CYCLES
) (
	input  wire logic pclk,
	input  wire logic presetn,
	pmwc_if.dev       link,
	input  wire logic supply_good,
	input  wire logic watchdog_timeout,
	input  wire logic vcc_above_high,
	input  wire logic vcc_below_low,
	output logic      osc_en,
	output logic      periph_clk_en
);
	localparam int CW = $clog2(POR_CYCLES + 1);

	typedef enum logic [1:0] {
		ST_DELAY = 2'b00,
		ST_RUN   = 2'b01,
		ST_HALT  = 2'b10,
		ST_STOP  = 2'b11
	} pmwc_state_e;

	pmwc_state_e st_r, st_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic          sup_q_r, sup_q_nxt;
	logic          warm_r, warm_nxt;
	logic          dly_r, dly_nxt;
	logic          pol_r, pol_nxt;
	logic [2:0]    src_r, src_nxt;
	logic          mon_en_r, mon_en_nxt;
	logic          hi_r, hi_nxt;
	logic          lo_r, lo_nxt;
	logic          interrupt_request_five_r, interrupt_request_five_nxt;
	logic          mask5_r, mask5_nxt;
	logic          req5_r, req5_nxt;
	logic          ack_r, ack_nxt;
	logic [7:0]    rdata_r, rdata_nxt;
	logic          exec_r, exec_nxt;
	logic          cpuclk_r, cpuclk_nxt;
	logic          osc_r, osc_nxt;
	logic          per_r, per_nxt;
	logic          rst_pulse_r, rst_pulse_nxt;
	logic          wake_hit;
	logic          cold;
	logic          wr;

	// level of the chosen source, turned to active-high by the polarity bit
	function automatic logic wake_level(input logic [2:0] sel, input logic [7:0] p2,
		input logic [7:0] p2_out, input logic [3:0] pins, input logic pol);
		logic [7:0] p2_in;
		logic       lvl;
		logic       ok;
		p2_in = p2 & ~p2_out; // [R12]
		lvl = 1'b0;
		ok = 1'b1;
		unique case (sel) // [R11]
			3'b010:  lvl = pins[0];
			3'b011:  lvl = pins[1];
			3'b100:  lvl = pins[2];
			3'b101:  lvl = pins[3];
			3'b110:  lvl = ~|p2_in[3:0];
			3'b111:  lvl = ~|p2_in;
			default: ok = 1'b0;
		endcase
		return ok & (pol ? lvl : ~lvl); // [R13]
	endfunction

	assign wake_hit = wake_level(src_r, link.port2_level, link.port2_is_out, link.wake_pins, pol_r);
	assign cold     = (supply_good & ~sup_q_r) | watchdog_timeout;
	assign wr       = link.reg_stb & link.reg_wr;

	always_comb begin
		st_nxt        = st_r;
		cnt_nxt       = cnt_r;
		warm_nxt      = warm_r;
		rst_pulse_nxt = 1'b0;
		sup_q_nxt     = supply_good;
		dly_nxt       = dly_r;
		pol_nxt       = pol_r;
		src_nxt       = src_r;
		mon_en_nxt    = mon_en_r;
		mask5_nxt     = mask5_r;
		interrupt_request_five_nxt      = interrupt_request_five_r;
		ack_nxt       = link.reg_stb;
		rdata_nxt     = rdata_r;
		if (wr) begin
			unique case (link.reg_addr)
				pmwc_pkg::REG_SUPPLY: mon_en_nxt = link.reg_wdata[pmwc_pkg::SUP_EN]; // [R15]
				pmwc_pkg::REG_STOPCFG: begin
					src_nxt = link.reg_wdata[pmwc_pkg::CFG_SRC_LO +: 3];
					dly_nxt = link.reg_wdata[pmwc_pkg::CFG_DLY];
					pol_nxt = link.reg_wdata[pmwc_pkg::CFG_POL];
				end
				pmwc_pkg::REG_IRQ: interrupt_request_five_nxt = interrupt_request_five_r & link.reg_wdata[pmwc_pkg::IRQ_FIVE];
				pmwc_pkg::REG_MASK: mask5_nxt = link.reg_wdata[pmwc_pkg::IRQ_FIVE];
				default: ;
			endcase
		end
		// flags track the comparators live, only while monitoring
		hi_nxt = mon_en_r & vcc_above_high; // [R16]
		lo_nxt = mon_en_r & vcc_below_low; // [R16]
		// setting beats a same-cycle clear by software
		if (lo_r) begin
			interrupt_request_five_nxt = 1'b1; // [R17]
		end
		// registered so the core sees the request straight from a flop
		req5_nxt = interrupt_request_five_nxt & mask5_nxt; // [R18]
		unique case (st_r)
			ST_DELAY: begin
				cnt_nxt = cnt_r + 1'b1;
				if (cnt_r >= CW'(POR_CYCLES - 1)) begin // [R2]
					st_nxt        = ST_RUN; // [R20]
					rst_pulse_nxt = 1'b1; // [R9]
				end
			end
			ST_RUN: begin
				if (link.instr_stb && link.instr_op == pmwc_pkg::OP_STOP) begin
					st_nxt = ST_STOP; // [R8]
				end else if (link.instr_stb && link.instr_op == pmwc_pkg::OP_HALT) begin
					st_nxt = ST_HALT; // [R6]
				end
			end
			ST_HALT: begin
				if (link.core_irq_pend || (interrupt_request_five_r && mask5_r)) begin
					st_nxt = ST_RUN; // [R7]
				end
			end
			ST_STOP: begin
				// no fast-wake debounce: the source is trusted to stay active long enough
				if (wake_hit) begin // [R4]
					warm_nxt = 1'b1; // [R14]
					cnt_nxt  = '0;
					if (dly_r) begin
						st_nxt = ST_DELAY; // [R1]
					end else begin
						st_nxt        = ST_RUN; // [R3]
						rst_pulse_nxt = 1'b1; // [R9]
					end
				end
			end
		endcase
		if (cold) begin
			st_nxt        = ST_DELAY; // [R1]
			cnt_nxt       = '0;
			warm_nxt      = 1'b0; // [R14]
			rst_pulse_nxt = 1'b0;
			dly_nxt       = pmwc_pkg::RST_DLY; // [R3]
			if (supply_good & ~sup_q_r) begin
				pol_nxt = pmwc_pkg::RST_POL; // [R13]
			end
		end
		if (link.reg_stb) begin
			unique case (link.reg_addr)
				pmwc_pkg::REG_SUPPLY:  rdata_nxt = {5'b0, hi_r, lo_r, mon_en_r};
				pmwc_pkg::REG_STOPCFG: rdata_nxt = {warm_r, pol_r, dly_r, src_r, 2'b00};
				pmwc_pkg::REG_IRQ:     rdata_nxt = {2'b00, interrupt_request_five_r, 5'b0};
				pmwc_pkg::REG_MASK:    rdata_nxt = {2'b00, mask5_r, 5'b0};
				default:               rdata_nxt = 8'h00;
			endcase
		end
		exec_nxt   = (st_nxt == ST_RUN) || (st_nxt == ST_HALT); // [R20]
		cpuclk_nxt = (st_nxt == ST_RUN); // [R6]
		osc_nxt    = (st_nxt != ST_STOP); // [R8]
		per_nxt    = (st_nxt != ST_STOP); // [R6]
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r        <= ST_DELAY;
			cnt_r       <= '0;
			sup_q_r     <= 1'b0;
			warm_r      <= 1'b0;
			dly_r       <= pmwc_pkg::RST_DLY;
			pol_r       <= pmwc_pkg::RST_POL;
			src_r       <= 3'h0;
			mon_en_r    <= 1'b0;
			hi_r        <= 1'b0;
			lo_r        <= 1'b0;
			interrupt_request_five_r      <= 1'b0;
			mask5_r     <= 1'b0;
			req5_r      <= 1'b0;
			ack_r       <= 1'b0;
			rdata_r     <= 8'h00;
			exec_r      <= 1'b0;
			cpuclk_r    <= 1'b0;
			osc_r       <= 1'b1;
			per_r       <= 1'b1;
			rst_pulse_r <= 1'b0;
		end else begin
			st_r        <= st_nxt;
			cnt_r       <= cnt_nxt;
			sup_q_r     <= sup_q_nxt;
			warm_r      <= warm_nxt;
			dly_r       <= dly_nxt;
			pol_r       <= pol_nxt;
			src_r       <= src_nxt;
			mon_en_r    <= mon_en_nxt;
			hi_r        <= hi_nxt;
			lo_r        <= lo_nxt;
			interrupt_request_five_r      <= interrupt_request_five_nxt;
			mask5_r     <= mask5_nxt;
			req5_r      <= req5_nxt;
			ack_r       <= ack_nxt;
			rdata_r     <= rdata_nxt;
			exec_r      <= exec_nxt;
			cpuclk_r    <= cpuclk_nxt;
			osc_r       <= osc_nxt;
			per_r       <= per_nxt;
			rst_pulse_r <= rst_pulse_nxt;
		end
	end

	assign link.reg_ack    = ack_r;
	assign link.reg_rdata  = rdata_r;
	assign link.interrupt_request_five_req   = req5_r;
	assign link.exec_en    = exec_r;
	assign link.cpu_clk_en = cpuclk_r;
	assign link.restart    = rst_pulse_r;
	assign osc_en          = osc_r;
	assign periph_clk_en   = per_r;
endmodule

//--- verilog/pmwc_host.sv
// processor-core side: apb-driven instruction, register and wake pin agent
`timescale 1ns/1ps
module pmwc_host (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	pmwc_if.host             link
);
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_OP   = 2'b01,
		H_DEV  = 2'b10
	} pmwc_hstate_e;

	pmwc_hstate_e st_r, st_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic        pready_r, pready_nxt;
	logic        pslverr_r, pslverr_nxt;
	logic        stb_r, stb_nxt;
	logic [7:0]  op_r, op_nxt;
	logic [7:0]  held_r, held_nxt;
	logic        rstb_r, rstb_nxt;
	logic        rwr_r, rwr_nxt;
	logic [7:0]  raddr_r, raddr_nxt;
	logic [7:0]  rwd_r, rwd_nxt;
	logic [7:0]  rdat_r, rdat_nxt;
	logic [19:0] pins_r, pins_nxt;
	logic        cirq_r, cirq_nxt;
	logic        seen_r, seen_nxt;
	logic        acc;
	logic        clr_seen;

	assign acc = psel & penable & ~pready_r;

	always_comb begin
		st_nxt      = st_r;
		prdata_nxt  = prdata_r;
		pready_nxt  = 1'b0;
		pslverr_nxt = 1'b0;
		stb_nxt     = 1'b0;
		op_nxt      = op_r;
		held_nxt    = held_r;
		rstb_nxt    = 1'b0;
		rwr_nxt     = rwr_r;
		raddr_nxt   = raddr_r;
		rwd_nxt     = rwd_r;
		rdat_nxt    = rdat_r;
		pins_nxt    = pins_r;
		cirq_nxt    = cirq_r;
		clr_seen    = 1'b0;
		unique case (st_r)
			H_IDLE: begin
				if (acc) begin
					pready_nxt = 1'b1;
					prdata_nxt = 32'h0000_0000;
					unique case (paddr)
						pmwc_pkg::APB_CMD: begin
							if (pwrite) begin
								stb_nxt = 1'b1;
								op_nxt  = pwdata[7:0];
								// sleep orders get the pipeline-flush no-op first
								if (pwdata[7:0] == pmwc_pkg::OP_STOP || pwdata[7:0] == pmwc_pkg::OP_HALT) begin
									op_nxt     = pmwc_pkg::OP_NOP; // [R10]
									held_nxt   = pwdata[7:0];
									pready_nxt = 1'b0;
									st_nxt     = H_OP;
								end
							end
						end
						pmwc_pkg::APB_DEVREG: begin
							if (pwrite) begin
								rstb_nxt   = 1'b1;
								rwr_nxt    = pwdata[pmwc_pkg::DEV_WR_BIT];
								raddr_nxt  = pwdata[15:8];
								rwd_nxt    = pwdata[7:0];
								pready_nxt = 1'b0;
								st_nxt     = H_DEV;
							end else begin
								prdata_nxt = {24'h00_0000, rdat_r};
							end
						end
						pmwc_pkg::APB_PINS: begin
							if (pwrite) begin
								pins_nxt = pwdata[19:0];
							end
							prdata_nxt = {12'h000, pins_r};
						end
						pmwc_pkg::APB_CORE_IRQ: begin
							if (pwrite) begin
								cirq_nxt = pwdata[0];
							end
							prdata_nxt = {31'h0000_0000, cirq_r};
						end
						pmwc_pkg::APB_STATUS: begin
							clr_seen   = pwrite & pwdata[pmwc_pkg::STAT_SEEN];
							prdata_nxt = {28'h000_0000, seen_r, link.interrupt_request_five_req, link.cpu_clk_en, link.exec_en};
						end
						default: pslverr_nxt = 1'b1;
					endcase
				end
			end
			H_OP: begin
				stb_nxt    = 1'b1;
				op_nxt     = held_r;
				pready_nxt = 1'b1;
				st_nxt     = H_IDLE;
			end
			H_DEV: begin
				if (link.reg_ack) begin
					rdat_nxt   = link.reg_rdata;
					pready_nxt = 1'b1;
					st_nxt     = H_IDLE;
				end
			end
			default: st_nxt = H_IDLE;
		endcase
		// a restart in the clearing cycle stays recorded
		seen_nxt = link.restart | (seen_r & ~clr_seen);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r      <= H_IDLE;
			prdata_r  <= 32'h0000_0000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			stb_r     <= 1'b0;
			op_r      <= 8'h00;
			held_r    <= 8'h00;
			rstb_r    <= 1'b0;
			rwr_r     <= 1'b0;
			raddr_r   <= 8'h00;
			rwd_r     <= 8'h00;
			rdat_r    <= 8'h00;
			pins_r    <= 20'h0_0000;
			cirq_r    <= 1'b0;
			seen_r    <= 1'b0;
		end else begin
			st_r      <= st_nxt;
			prdata_r  <= prdata_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			stb_r     <= stb_nxt;
			op_r      <= op_nxt;
			held_r    <= held_nxt;
			rstb_r    <= rstb_nxt;
			rwr_r     <= rwr_nxt;
			raddr_r   <= raddr_nxt;
			rwd_r     <= rwd_nxt;
			rdat_r    <= rdat_nxt;
			pins_r    <= pins_nxt;
			cirq_r    <= cirq_nxt;
			seen_r    <= seen_nxt;
		end
	end

	assign prdata             = prdata_r;
	assign pready             = pready_r;
	assign pslverr            = pslverr_r;
	assign link.instr_stb     = stb_r;
	assign link.instr_op      = op_r;
	assign link.reg_stb       = rstb_r;
	assign link.reg_wr        = rwr_r;
	assign link.reg_addr      = raddr_r;
	assign link.reg_wdata     = rwd_r;
	assign link.core_irq_pend = cirq_r;
	assign link.port2_level   = pins_r[7:0];
	assign link.port2_is_out  = pins_r[15:8];
	assign link.wake_pins     = pins_r[19:16];
endmodule

//--- verification/pmwc_asserts.sv
// concurrent checks on the controller to core link
`timescale 1ns/1ps
module pmwc_asserts #(
	parameter int POR_CYCLES = pmwc_pkg::POR_CYCLES
) (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       instr_stb,
	input wire logic [7:0] instr_op,
	input wire logic       reg_stb,
	input wire logic       reg_ack,
	input wire logic [7:0] reg_rdata,
	input wire logic       core_irq_pend,
	input wire logic       interrupt_request_five_req,
	input wire logic       exec_en,
	input wire logic       cpu_clk_en,
	input wire logic       restart
);
	logic [31:0] low_r;
	logic [31:0] low_nxt;
	logic        ran_r;
	logic        ran_nxt;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// only the first release is timed; fast stop wake is short on purpose
	always_comb begin
		low_nxt = exec_en ? 32'h0000_0000 : low_r + 32'h0000_0001;
		ran_nxt = ran_r | exec_en;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_r <= 32'h0000_0000;
			ran_r <= 1'b0;
		end else begin
			low_r <= low_nxt;
			ran_r <= ran_nxt;
		end
	end

	ack_after_stb_a: assert property (reg_stb |=> reg_ack)
		else $error("reg_ack missing after reg_stb");
	rdata_hold_a: assert property (!reg_ack |-> $stable(reg_rdata))
		else $error("reg_rdata moved without reg_ack");
	halt_gates_a: assert property (instr_stb && instr_op == pmwc_pkg::OP_HALT && cpu_clk_en
		|=> !cpu_clk_en && exec_en) else $error("halt did not gate only cpu clock");
	halt_holds_a: assert property (exec_en && !cpu_clk_en && !core_irq_pend && !interrupt_request_five_req
		|=> !cpu_clk_en) else $error("halt left without interrupt");
	halt_exit_a: assert property (exec_en && !cpu_clk_en && core_irq_pend |=> cpu_clk_en)
		else $error("halt not left after interrupt");
	stop_ends_a: assert property (instr_stb && instr_op == pmwc_pkg::OP_STOP && cpu_clk_en
		|=> !exec_en && !cpu_clk_en) else $error("stop did not halt execution");
	rise_restart_a: assert property ($rose(exec_en) |-> restart)
		else $error("execution resumed without restart");
	restart_pulse_a: assert property (restart |-> exec_en && cpu_clk_en ##1 !restart)
		else $error("restart pulse malformed");
	por_delay_a: assert property ($rose(exec_en) && !ran_r |-> low_r >= POR_CYCLES - 1)
		else $error("power-on delay too short");
	nop_first_a: assert property (instr_stb && (instr_op == pmwc_pkg::OP_STOP ||
		instr_op == pmwc_pkg::OP_HALT) |-> $past(instr_stb) && $past(instr_op) == pmwc_pkg::OP_NOP)
		else $error("sleep opcode without nop before it");
endmodule

//--- verification/tb_power_mode_and_wakeup_control.sv
// self-checking bench for the controller and core side pair
`timescale 1ns/1ps
module tb_power_mode_and_wakeup_control;
	localparam int P = 20;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic        supply_good, watchdog_timeout, vcc_above_high, vcc_below_low, osc_en, periph_clk_en;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	int          err_total, num_checks, c;
	logic [7:0]  cf [7] = '{8'h48, 8'h4c, 8'h50, 8'h54, 8'h58, 8'h5c, 8'h28};
	logic [19:0] idl[7] = '{20'h0_00ff, 20'h0_00ff, 20'h0_00ff, 20'h0_00ff, 20'h0_00ff, 20'h0_00ff, 20'h1_00ff};
	logic [19:0] wk [7] = '{20'h1_00ff, 20'h2_00ff, 20'h4_00ff, 20'h8_00ff, 20'h0_0101, 20'h0_0000, 20'h0_00ff};

	pmwc_if lnk();
	pmwc_device #(.POR_CYCLES(P)) i_pmwc_device (.pclk(pclk), .presetn(presetn), .link(lnk),
		.supply_good(supply_good), .watchdog_timeout(watchdog_timeout), .vcc_above_high(vcc_above_high),
		.vcc_below_low(vcc_below_low), .osc_en(osc_en), .periph_clk_en(periph_clk_en));
	pmwc_host i_pmwc_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(lnk));
	pmwc_asserts #(.POR_CYCLES(P)) i_pmwc_asserts (.pclk(pclk), .presetn(presetn),
		.instr_stb(lnk.instr_stb), .instr_op(lnk.instr_op), .reg_stb(lnk.reg_stb), .reg_ack(lnk.reg_ack),
		.reg_rdata(lnk.reg_rdata), .core_irq_pend(lnk.core_irq_pend), .interrupt_request_five_req(lnk.interrupt_request_five_req),
		.exec_en(lnk.exec_en), .cpu_clk_en(lnk.cpu_clk_en), .restart(lnk.restart));

	task automatic results;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
		num_checks++;
		if (g !== x) begin
			err_total++;
			$display("[ERR] %s exp %h got %h", s, x, g);
		end
	endtask

	// holds the whole request until the edge that samples pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		r = prdata;
		e = pslverr;
		chk("pready", 1'b1, pready);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic dw(input logic [7:0] i, input logic [7:0] d);
		apb(1'b1, pmwc_pkg::APB_DEVREG, {15'h0000, 1'b1, i, d});
	endtask

	task automatic dr(input logic [7:0] i);
		apb(1'b1, pmwc_pkg::APB_DEVREG, {15'h0000, 1'b0, i, 8'h00});
		apb(1'b0, pmwc_pkg::APB_DEVREG, 32'h0000_0000);
	endtask

	task automatic st;
		apb(1'b0, pmwc_pkg::APB_STATUS, 32'h0000_0000);
	endtask

	task automatic wex;
		c = 0;
		#1;
		while (lnk.exec_en !== 1'b1 && c < 500) begin
			@(posedge pclk);
			#1;
			c++;
		end
	endtask

	task automatic t_por;
		wex;
		chk("por_wait", 1'b1, c >= P - 2);
		st;
		chk("por_status", 32'h0000_000b, r);
		dr(pmwc_pkg::REG_STOPCFG);
		chk("cfg_reset", 8'h20, r[7:0] & 8'he0);
	endtask

	task automatic t_sup;
		@(posedge pclk);
		vcc_below_low <= 1'b1;
		dr(pmwc_pkg::REG_SUPPLY);
		chk("sup_off", 8'h00, r[7:0]);
		dw(pmwc_pkg::REG_SUPPLY, 8'h01);
		dr(pmwc_pkg::REG_SUPPLY);
		chk("sup_low", 8'h03, r[7:0]);
		dr(pmwc_pkg::REG_IRQ);
		chk("req5_set", 1'b1, r[5]);
		st;
		chk("req5_masked", 1'b0, r[2]);
		dw(pmwc_pkg::REG_MASK, 8'h20);
		st;
		chk("req5_unmasked", 1'b1, r[2]);
		@(posedge pclk);
		vcc_below_low <= 1'b0;
		vcc_above_high <= 1'b1;
		dr(pmwc_pkg::REG_SUPPLY);
		chk("sup_high", 8'h05, r[7:0]);
		dr(pmwc_pkg::REG_IRQ);
		chk("req5_latched", 1'b1, r[5]);
		dw(pmwc_pkg::REG_IRQ, 8'h00);
		dr(pmwc_pkg::REG_IRQ);
		chk("req5_clear", 1'b0, r[5]);
		dw(pmwc_pkg::REG_MASK, 8'h00);
		dw(pmwc_pkg::REG_SUPPLY, 8'h00);
		@(posedge pclk);
		vcc_above_high <= 1'b0;
	endtask

	task automatic t_halt;
		apb(1'b1, pmwc_pkg::APB_CMD, 32'h0000_007f);
		st;
		chk("halt_st", 2'b01, r[1:0]);
		chk("halt_osc", 2'b11, {osc_en, periph_clk_en});
		st;
		chk("halt_stay", 2'b01, r[1:0]);
		apb(1'b1, pmwc_pkg::APB_CORE_IRQ, 32'h0000_0001);
		st;
		chk("halt_exit", 2'b11, r[1:0]);
		apb(1'b1, pmwc_pkg::APB_CORE_IRQ, 32'h0000_0000);
		// unmask first so a low supply at enable is not missed
		dw(pmwc_pkg::REG_MASK, 8'h20);
		apb(1'b1, pmwc_pkg::APB_CMD, 32'h0000_007f);
		st;
		chk("halt_wait", 3'b001, r[2:0]);
		@(posedge pclk);
		vcc_below_low <= 1'b1;
		dw(pmwc_pkg::REG_SUPPLY, 8'h01);
		repeat (4) @(posedge pclk);
		st;
		chk("halt_lvd_exit", 3'b111, r[2:0]);
		@(posedge pclk);
		vcc_below_low <= 1'b0;
		dw(pmwc_pkg::REG_SUPPLY, 8'h00);
		dw(pmwc_pkg::REG_IRQ, 8'h00);
		dw(pmwc_pkg::REG_MASK, 8'h00);
	endtask

	// one pass per wake source, then pin 0 again at low level with delay, as a crystal needs
	task automatic t_stop;
		for (int i = 0; i < 7; i++) begin
			apb(1'b1, pmwc_pkg::APB_PINS, {12'h000, idl[i]});
			dw(pmwc_pkg::REG_STOPCFG, cf[i]);
			apb(1'b1, pmwc_pkg::APB_STATUS, 32'h0000_0008);
			apb(1'b1, pmwc_pkg::APB_CMD, 32'h0000_006f);
			st;
			chk("stop_st", 4'h0, r[3:0]);
			chk("stop_osc", 2'b00, {osc_en, periph_clk_en});
			apb(1'b1, pmwc_pkg::APB_PINS, {12'h000, wk[i]});
			wex;
			chk("wake_dly", 1'b1, cf[i][5] ? c >= P - 4 : c < 4);
			st;
			chk("wake_st", 32'h0000_000b, r);
			dr(pmwc_pkg::REG_STOPCFG);
			chk("warm", 1'b1, r[7]);
		end
	endtask

	task automatic t_wdt;
		dw(pmwc_pkg::REG_STOPCFG, 8'h40);
		apb(1'b1, pmwc_pkg::APB_CMD, 32'h0000_006f);
		apb(1'b1, pmwc_pkg::APB_PINS, 32'h0000_0000);
		st;
		chk("src0_stays", 2'b00, r[1:0]);
		@(posedge pclk);
		watchdog_timeout <= 1'b1;
		@(posedge pclk);
		watchdog_timeout <= 1'b0;
		wex;
		chk("wdt_dly", 1'b1, c >= P - 2);
		dr(pmwc_pkg::REG_STOPCFG);
		chk("cold", 3'b011, r[7:5]);
	endtask

	// supply dip in mid-run: cold start, polarity back to low level
	task automatic t_pwr;
		@(posedge pclk);
		supply_good <= 1'b0;
		repeat (2) @(posedge pclk);
		supply_good <= 1'b1;
		@(posedge pclk);
		wex;
		chk("pwr_dly", 1'b1, c >= P - 4);
		dr(pmwc_pkg::REG_STOPCFG);
		chk("pwr_cfg", 3'b001, r[7:5]);
	endtask

	task automatic t_err;
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk("slverr", 1'b1, e);
		chk("err_data", 32'h0000_0000, r);
	endtask

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	initial begin
		repeat (6000) @(posedge pclk);
		err_total++;
		$display("[ERR] run exp done got hang");
		results;
	end

	initial begin
		{presetn, psel, penable, pwrite, watchdog_timeout, vcc_above_high, vcc_below_low} = 7'h00;
		supply_good = 1'b1;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_por;
		t_sup;
		t_halt;
		t_stop;
		t_wdt;
		t_pwr;
		t_err;
		results;
	end
endmodule
